// >>> include/power_state_manager_consts.svh
/*
 Constants for the power-state manager: state codes, clock rates, dividers.
 Assumes inclusion by bare name from the design files.
*/
`ifndef POWER_STATE_MANAGER_CONSTS_SVH
`define POWER_STATE_MANAGER_CONSTS_SVH

`define PSM_SYS_CLK_KHZ      250000
`define PSM_ACTIVE_CLK_KHZ   12000
`define PSM_IDLE_CLK_KHZ     5000
`define PSM_SLEEP_CLK_KHZ    100
`define PSM_ACTIVE_DIV       (`PSM_SYS_CLK_KHZ / `PSM_ACTIVE_CLK_KHZ)
`define PSM_IDLE_DIV         (`PSM_SYS_CLK_KHZ / `PSM_IDLE_CLK_KHZ)
`define PSM_SLEEP_DIV        (`PSM_SYS_CLK_KHZ / `PSM_SLEEP_CLK_KHZ)
`define PSM_DIV_W            12
`define PSM_ST_ACTIVE        3'h1
`define PSM_ST_IDLE          3'h2
`define PSM_ST_SLEEP         3'h4

`endif

// >>> include/power_state_pkg.sv
/*
 Types shared by the power-state manager files.
 Assumes power_state_manager_consts.svh is on the include path.
*/
`include "power_state_manager_consts.svh"
package power_state_pkg;
	typedef enum logic [2:0] {
		PS_ACTIVE = `PSM_ST_ACTIVE,
		PS_IDLE   = `PSM_ST_IDLE,
		PS_SLEEP  = `PSM_ST_SLEEP
	} pwr_state_t;

	// Feature and oscillator enables for the current state
	typedef struct packed {
		logic fastOscEn;
		logic slowOscEn;
		logic attachDetEn;
		logic pdMsgEn;
		logic i2cEn;
		logic spiEn;
	} feature_en_t;
endpackage

// >>> core/core_clk_divider.sv
/*
 Divider producing a one-cycle enable at a selectable rate.
 Assumes divide ratio held steady except at state changes.
*/
`timescale 1ns/1ps
`include "power_state_manager_consts.svh"
module core_clk_divider #(
	parameter int W = `PSM_DIV_W
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] divRatio,
	output logic              tickEn
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] ratio_ff;

	// Rate change restarts the count so no short period leaks out
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ratio_ff <= '0;
		end else begin
			ratio_ff <= divRatio;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || divRatio != ratio_ff) begin
			cnt_ff <= '0;
		end else if (cnt_ff >= divRatio - W'(1)) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tickEn <= 1'b0;
		end else begin
			tickEn <= divRatio == ratio_ff && cnt_ff >= divRatio - W'(1);
		end
	end
endmodule // core_clk_divider

// >>> core/power_state_manager.sv
/*
 Power-state manager: active/idle/sleep selection, core clock enable,
 oscillator and feature enables, wake handling, sink-only restriction.
 Assumes event inputs are pins from outside this clock domain; a host on
 the two-wire bus requests state changes through hostReq pins.
*/
// What this block does
// - Always exactly one of active, idle, sleep; sleep only while unconnected.
// - Core clock 12 MHz active (code divides by 20, 12.5 MHz), 4-6 MHz idle, 100 kHz sleep; fast osc off.
// - Attach detect always; PD, four-wire active only; two-wire not asleep.
// - Attach/detach or addressed two-wire traffic wakes from idle or sleep.
// - Protocol message wakes idle to active, never from sleep.
// - The message that caused a wake is dropped, later ones are handled.
// - Internal 3.3 V rail fed from cable supply forces sink-only role.
// - Host on two-wire bus configures and controls the device.
// - Boot loads configuration bundle over two-wire or four-wire interface.
`timescale 1ns/1ps
`include "power_state_manager_consts.svh"
module power_state_manager #(
	parameter int DIV_W = `PSM_DIV_W
) (
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	input  wire logic                       portConnected,
	input  wire logic                       attachEvent,
	input  wire logic                       i2cAddrMatch,
	input  wire logic                       pdMsgIn,
	input  wire logic                       rail3v3FromVbus,
	input  wire logic                       bootLoadDone,
	input  wire logic                       hostReqIdle,
	input  wire logic                       hostReqSleep,
	output power_state_pkg::pwr_state_t     pwrState,
	output power_state_pkg::feature_en_t    featEn,
	output logic                            coreTick,
	output logic                            pdMsgAccept,
	output logic                            sinkOnly,
	output logic                            bootBusy
);
	// Three-stage pin synchronisers, one generate loop
	localparam int NPIN = 8;
	logic [NPIN-1:0] pinRaw;
	logic [NPIN-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
	assign pinRaw = {hostReqSleep, hostReqIdle, bootLoadDone,
		rail3v3FromVbus, pdMsgIn, i2cAddrMatch, attachEvent, portConnected};
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge core_clk) begin
				if (rst) begin
					s1_ff[gi]  <= 1'b0;
					s2_ff[gi]  <= 1'b0;
					s3_ff[gi]  <= 1'b0;
					pin_ff[gi] <= 1'b0;
				end else begin
					s1_ff[gi] <= pinRaw[gi];
					s2_ff[gi] <= s1_ff[gi];
					s3_ff[gi] <= s2_ff[gi];
					if (s2_ff[gi] == s3_ff[gi]) begin
						pin_ff[gi] <= s3_ff[gi];
					end
				end
			end
		end
	endgenerate

	logic conn, attEv, i2cHit, pdIn, railVbus, bootDone, reqIdle, reqSleep;
	assign {reqSleep, reqIdle, bootDone, railVbus, pdIn, i2cHit, attEv,
		conn} = pin_ff;

	// Edge detection on settled levels
	logic attEv_ff, i2cHit_ff, pdIn_ff;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			attEv_ff  <= 1'b0;
			i2cHit_ff <= 1'b0;
			pdIn_ff   <= 1'b0;
		end else begin
			attEv_ff  <= attEv;
			i2cHit_ff <= i2cHit;
			pdIn_ff   <= pdIn;
		end
	end
	logic attRise, i2cRise, pdRise;
	assign attRise = attEv && !attEv_ff;
	assign i2cRise = i2cHit && !i2cHit_ff;
	assign pdRise  = pdIn && !pdIn_ff;

	// Boot: hold active until the configuration bundle is loaded
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bootBusy <= 1'b1;
		end else if (bootDone) begin
			bootBusy <= 1'b0;
		end
	end

	power_state_pkg::pwr_state_t state_ff, nxt_state;
	logic wake;
	assign wake = attRise || i2cRise;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			power_state_pkg::PS_ACTIVE: begin
				// Host commands arrive over two-wire bus
				if (!bootBusy && reqSleep && !conn) begin
					nxt_state = power_state_pkg::PS_SLEEP;
				end else if (!bootBusy && reqIdle) begin
					nxt_state = power_state_pkg::PS_IDLE;
				end
			end
			power_state_pkg::PS_IDLE: begin
				if (wake || pdRise) begin
					nxt_state = power_state_pkg::PS_ACTIVE;
				end else if (reqSleep && !conn) begin
					nxt_state = power_state_pkg::PS_SLEEP;
				end
			end
			power_state_pkg::PS_SLEEP: begin
				// Protocol traffic ignored here; link is dead anyway
				if (wake || conn) begin
					nxt_state = power_state_pkg::PS_ACTIVE;
				end
			end
			default: nxt_state = power_state_pkg::PS_ACTIVE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_ff <= power_state_pkg::PS_ACTIVE;
		end else begin
			state_ff <= nxt_state;
		end
	end
	assign pwrState = state_ff;

	// Drop the waking message until its line goes quiet
	logic dropMsg_ff;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dropMsg_ff <= 1'b0;
		end else if (state_ff == power_state_pkg::PS_IDLE && pdRise) begin
			dropMsg_ff <= 1'b1;
		end else if (!pdIn) begin
			dropMsg_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pdMsgAccept <= 1'b0;
		end else begin
			pdMsgAccept <= pdRise && state_ff == power_state_pkg::PS_ACTIVE
				&& !dropMsg_ff;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sinkOnly <= 1'b0;
		end else begin
			sinkOnly <= railVbus;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			// Reset state is active, so every enable is on
			featEn <= '1;
		end else begin
			featEn.fastOscEn <= nxt_state != power_state_pkg::PS_SLEEP;
			featEn.slowOscEn   <= 1'b1;
			featEn.attachDetEn <= 1'b1;
			featEn.pdMsgEn  <= nxt_state == power_state_pkg::PS_ACTIVE;
			featEn.spiEn    <= nxt_state == power_state_pkg::PS_ACTIVE;
			featEn.i2cEn    <= nxt_state != power_state_pkg::PS_SLEEP;
		end
	end

	// Core clock rate per state
	logic [DIV_W-1:0] divSel;
	always_comb begin
		case (state_ff)
			power_state_pkg::PS_IDLE:  divSel = DIV_W'(`PSM_IDLE_DIV);
			power_state_pkg::PS_SLEEP: divSel = DIV_W'(`PSM_SLEEP_DIV);
			default:                   divSel = DIV_W'(`PSM_ACTIVE_DIV);
		endcase
	end

	core_clk_divider #(.W(DIV_W)) i_core_clk_divider (
		.core_clk (core_clk),
		.rst      (rst),
		.divRatio (divSel),
		.tickEn   (coreTick)
	);

	property p_sleep_unconn;
		@(posedge core_clk) disable iff (rst)
		nxt_state == power_state_pkg::PS_SLEEP |-> !conn;
	endproperty
	a_sleep_unconn: assert property (p_sleep_unconn)
		else $error("sleep while connected");
	property p_onehot;
		@(posedge core_clk) disable iff (rst) $onehot(state_ff);
	endproperty
	a_onehot: assert property (p_onehot)
		else $error("state not one-hot");
	property p_osc;
		@(posedge core_clk) disable iff (rst)
		featEn.slowOscEn &&
		featEn.fastOscEn == (state_ff != power_state_pkg::PS_SLEEP);
	endproperty
	a_osc: assert property (p_osc)
		else $error("oscillator enables wrong");
	property p_wake;
		@(posedge core_clk) disable iff (rst)
		state_ff != power_state_pkg::PS_ACTIVE && wake |=>
		state_ff == power_state_pkg::PS_ACTIVE;
	endproperty
	a_wake: assert property (p_wake)
		else $error("no wake");
	property p_pd_sleep;
		@(posedge core_clk) disable iff (rst)
		state_ff == power_state_pkg::PS_SLEEP && pdRise && !wake && !conn |=>
		state_ff == power_state_pkg::PS_SLEEP;
	endproperty
	a_pd_sleep: assert property (p_pd_sleep)
		else $error("protocol message woke sleep");
	property p_pd_idle;
		@(posedge core_clk) disable iff (rst)
		state_ff == power_state_pkg::PS_IDLE && pdRise |=>
		!pdMsgAccept ##1 !pdMsgAccept;
	endproperty
	a_pd_idle: assert property (p_pd_idle)
		else $error("waking message accepted");
	property p_accept;
		@(posedge core_clk) disable iff (rst)
		pdMsgAccept |-> $past(state_ff) == power_state_pkg::PS_ACTIVE;
	endproperty
	a_accept: assert property (p_accept)
		else $error("message accepted outside active");
	property p_sink;
		@(posedge core_clk) disable iff (rst)
		sinkOnly == $past(railVbus);
	endproperty
	a_sink: assert property (p_sink)
		else $error("sink-only does not follow rail source");
	property p_feat_idle;
		@(posedge core_clk) disable iff (rst)
		state_ff == power_state_pkg::PS_IDLE |->
		featEn.i2cEn && featEn.attachDetEn &&
		!featEn.pdMsgEn && !featEn.spiEn;
	endproperty
	a_feat_idle: assert property (p_feat_idle)
		else $error("idle feature enables wrong");
	property p_feat_sleep;
		@(posedge core_clk) disable iff (rst)
		state_ff == power_state_pkg::PS_SLEEP |->
		!featEn.i2cEn && featEn.attachDetEn &&
		!featEn.pdMsgEn && !featEn.spiEn;
	endproperty
	a_feat_sleep: assert property (p_feat_sleep)
		else $error("sleep feature enables wrong");
	property p_boot_hold;
		@(posedge core_clk) disable iff (rst)
		bootBusy && state_ff == power_state_pkg::PS_ACTIVE |=>
		state_ff == power_state_pkg::PS_ACTIVE;
	endproperty
	a_boot_hold: assert property (p_boot_hold)
		else $error("left active before boot finished");
endmodule // power_state_manager

// >>> tb/host_model.sv
/*
 Behavioural host on the two-wire bus: state requests, wake traffic, boot.
 Assumes the bench calls ask() from its own process, off the rising edge.
*/
`timescale 1ns/1ps
module host_model (
	input  wire logic core_clk,
	output logic      i2cAddrMatch,
	output logic      hostReqIdle,
	output logic      hostReqSleep,
	output logic      bootLoadDone
);
	initial begin
		i2cAddrMatch = 1'b0;
		hostReqIdle = 1'b0;
		hostReqSleep = 1'b0;
		bootLoadDone = 1'b0;
	end

	// Kind 0 idle, 1 sleep, 2 wake traffic, 3 bundle loaded
	task automatic ask(input int kind);
		@(negedge core_clk);
		hostReqIdle = (kind == 0);
		hostReqSleep = (kind == 1);
		i2cAddrMatch = (kind == 2);
		bootLoadDone = bootLoadDone || (kind == 3);
		// Held well past the input filter
		repeat (8) @(negedge core_clk);
		hostReqIdle = 1'b0;
		hostReqSleep = 1'b0;
		i2cAddrMatch = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask
endmodule // host_model

// >>> tb/power_state_manager_test.sv
/*
 Self-checking bench for the power-state manager.
 Assumes host_model on the host pins; all inputs change at falling edges.
*/
`timescale 1ns/1ps
`include "power_state_manager_consts.svh"
module power_state_manager_test;
	logic core_clk, rst, portConnected, attachEvent, pdMsgIn, rail3v3FromVbus;
	logic i2cAddrMatch, hostReqIdle, hostReqSleep, bootLoadDone;
	power_state_pkg::pwr_state_t pwrState;
	power_state_pkg::feature_en_t featEn;
	logic coreTick, pdMsgAccept, sinkOnly, bootBusy;
	int fail_count, comparisons, accCnt;

	power_state_manager i_power_state_manager (.core_clk(core_clk),
		.rst(rst), .portConnected(portConnected), .attachEvent(attachEvent),
		.i2cAddrMatch(i2cAddrMatch), .pdMsgIn(pdMsgIn),
		.rail3v3FromVbus(rail3v3FromVbus), .bootLoadDone(bootLoadDone),
		.hostReqIdle(hostReqIdle), .hostReqSleep(hostReqSleep),
		.pwrState(pwrState), .featEn(featEn), .coreTick(coreTick),
		.pdMsgAccept(pdMsgAccept), .sinkOnly(sinkOnly), .bootBusy(bootBusy));
	host_model i_host_model (.core_clk(core_clk), .i2cAddrMatch(i2cAddrMatch),
		.hostReqIdle(hostReqIdle), .hostReqSleep(hostReqSleep),
		.bootLoadDone(bootLoadDone));

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// Sampled mid-cycle, away from the edge that launches the pulse
	always @(negedge core_clk) if (pdMsgAccept === 1'b1) accCnt++;

	task automatic chk(input string nm, input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic st(input power_state_pkg::pwr_state_t exp);
		int n;
		n = 0;
		while (pwrState !== exp && n < 40) begin
			@(negedge core_clk);
			n++;
		end
		chk("pwrState", 16'(pwrState), 16'(exp));
	endtask

	// Events are edges, so one pulse held past the filter
	task automatic pulse(input int which);
		@(negedge core_clk);
		pdMsgIn = (which == 0);
		attachEvent = (which != 0);
		repeat (6) @(negedge core_clk);
		pdMsgIn = 1'b0;
		attachEvent = 1'b0;
		repeat (6) @(negedge core_clk);
	endtask

	task automatic gap(input int exp);
		int n;
		n = 0;
		@(posedge coreTick);
		@(negedge core_clk);
		do begin
			@(negedge core_clk);
			n++;
		end while (coreTick !== 1'b1 && n < 3000);
		chk("coreTick period", 16'(n), 16'(exp));
	endtask

	// Full run is near 22 us; the margin only guards a stuck wait
	initial begin
		#200us;
		fail_count++;
		stop_test();
	end

	task automatic test_boot;
		chk("bootBusy", 16'(bootBusy), 16'h0001);
		chk("featEn", 16'(featEn), 16'h003F);
		i_host_model.ask(0);
		st(power_state_pkg::PS_ACTIVE);
		i_host_model.ask(3);
		repeat (8) @(negedge core_clk);
		chk("bootBusy", 16'(bootBusy), 16'h0000);
		$display("test boot done");
	endtask

	task automatic test_idle_wake;
		int a0;
		i_host_model.ask(0);
		st(power_state_pkg::PS_IDLE);
		chk("featEn", 16'(featEn), 16'h003A);
		gap(`PSM_IDLE_DIV);
		a0 = accCnt;
		pulse(0);
		st(power_state_pkg::PS_ACTIVE);
		chk("accepts", 16'(accCnt - a0), 16'h0000);
		chk("featEn", 16'(featEn), 16'h003F);
		gap(`PSM_ACTIVE_DIV);
		pulse(0);
		chk("accepts", 16'(accCnt - a0), 16'h0001);
		i_host_model.ask(0);
		st(power_state_pkg::PS_IDLE);
		i_host_model.ask(2);
		st(power_state_pkg::PS_ACTIVE);
		$display("test idle wake done");
	endtask

	task automatic test_sleep_wake;
		int a0;
		portConnected = 1'b1;
		i_host_model.ask(1);
		st(power_state_pkg::PS_ACTIVE);
		portConnected = 1'b0;
		i_host_model.ask(1);
		st(power_state_pkg::PS_SLEEP);
		chk("featEn", 16'(featEn), 16'h0018);
		gap(`PSM_SLEEP_DIV);
		a0 = accCnt;
		pulse(0);
		st(power_state_pkg::PS_SLEEP);
		chk("accepts", 16'(accCnt - a0), 16'h0000);
		pulse(1);
		st(power_state_pkg::PS_ACTIVE);
		i_host_model.ask(1);
		st(power_state_pkg::PS_SLEEP);
		i_host_model.ask(2);
		st(power_state_pkg::PS_ACTIVE);
		i_host_model.ask(0);
		st(power_state_pkg::PS_IDLE);
		i_host_model.ask(1);
		st(power_state_pkg::PS_SLEEP);
		pulse(1);
		st(power_state_pkg::PS_ACTIVE);
		i_host_model.ask(0);
		st(power_state_pkg::PS_IDLE);
		pulse(1);
		st(power_state_pkg::PS_ACTIVE);
		$display("test sleep wake done");
	endtask

	task automatic test_rail;
		rail3v3FromVbus = 1'b1;
		repeat (8) @(negedge core_clk);
		chk("sinkOnly", 16'(sinkOnly), 16'h0001);
		rail3v3FromVbus = 1'b0;
		repeat (8) @(negedge core_clk);
		chk("sinkOnly", 16'(sinkOnly), 16'h0000);
		$display("test rail done");
	endtask

	initial begin
		fail_count = 0;
		comparisons = 0;
		accCnt = 0;
		portConnected = 1'b0;
		attachEvent = 1'b0;
		pdMsgIn = 1'b0;
		rail3v3FromVbus = 1'b0;
		rst = 1'b1;
		repeat (10) @(negedge core_clk);
		rst = 1'b0;
		test_boot();
		test_idle_wake();
		test_sleep_wake();
		test_rail();
		stop_test();
	end
endmodule // power_state_manager_test
